// *** bsg_consts.svh ***
`ifndef BSG_CONSTS_SVH
`define BSG_CONSTS_SVH

// i2c subaddress of the load-status word
`define BSG_SUB_LOAD_STATUS   8'h02
// load-status field positions
`define BSG_ST_READ_ERR       0
`define BSG_ST_NO_EEPROM      1
`define BSG_ST_LOAD_OK        2
`define BSG_ST_STRAP_HIGH     3
`define BSG_ST_INIT_DONE      4
// i2c addressing: eeprom probe base 1010 00x, slave base is a plain default
`define BSG_EEPROM_ADDR_BASE  6'h28
`define BSG_SLAVE_ADDR_BASE   6'h1A
// probe timeout: 100 ms at 250 MHz
`define BSG_PROBE_TIME_MS     100
`define BSG_CLK_KHZ           250000
// pin counts
`define BSG_IO_PINS           4
`define BSG_IN_PINS           2
`define BSG_SYNC_BITS         9

`endif

// *** bsg_ctrl_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module bsg_ctrl_model (
	input  wire logic        core_clk,  // device clock
	input  wire logic        reset_n,   // device reset, active low
	input  wire logic        ext_en,    // strap resistor fitted
	input  wire logic        ext_level, // strap resistor level
	input  wire logic        pin_out,   // device strap value
	input  wire logic        pin_oe,    // device strap enable
	input  wire logic [31:0] rd_data,   // status read data
	output var  logic        pin_wire,  // resolved strap line
	output var  logic        rd_en,     // status read strobe
	output var  logic [7:0]  subaddr    // status subaddress
);
	logic last;
	logic fell;

	initial rd_en = 1'b0;
	initial subaddr = 8'h0;

	// device drive beats the strap resistor; with neither the line floats up
	assign pin_wire = pin_oe ? pin_out : (ext_en ? ext_level : 1'b1);

	// sticky fall flag, so a late reader still sees completion
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			last <= 1'b0;
			fell <= 1'b0;
		end
		else
		begin
			last <= pin_wire;
			fell <= fell | (last & !pin_wire);
		end
	end

	// one status word; optionally only after the strap line has fallen
	task automatic read_word(input logic [7:0] sa, input bit after_fall,
		output logic [31:0] d, output bit ok);
		int n;
		n = 0;
		while (after_fall && !fell && n < 300)
		begin
			@(posedge core_clk);
			n++;
		end
		ok = (n < 300);
		@(posedge core_clk);
		#1;
		rd_en = 1'b1;
		subaddr = sa;
		@(posedge core_clk);
		#1;
		rd_en = 1'b0;
		d = rd_data;
	endtask
endmodule

`default_nettype wire

// *** bsg_pkg.sv ***
package bsg_pkg;

	// boot and fallback sequence
	typedef enum logic [3:0]
	{
		ST_HOUSE,
		ST_PROBE,
		ST_LOAD,
		ST_FB_SAMPLE,
		ST_FB_STATUS,
		ST_FB_DRIVE,
		ST_FALLBACK,
		ST_BOOT_DONE,
		ST_RUN
	} bsg_state_t;

endpackage

// *** bsg_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

// two-stage synchroniser for pin levels
module bsg_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             core_clk, // device clock
	input  wire logic             reset_n,  // async reset, active low
	input  wire logic [WIDTH-1:0] async_in, // raw pin levels
	output var  logic [WIDTH-1:0] sync_out  // levels safe for logic
);

	logic [WIDTH-1:0] stage_one;

	// first stage feeds only the second stage
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			stage_one <= '0;
			sync_out  <= '0;
		end
		else
		begin
			stage_one <= async_in;
			sync_out  <= stage_one;
		end
	end

endmodule

`default_nettype wire

// *** bsg_timer.sv ***
`timescale 1ns/10ps
`default_nettype none

// counts while run is high, flags once the count is reached
module bsg_timer #(
	parameter int CYCLES = 16
) (
	input  wire logic core_clk, // device clock
	input  wire logic reset_n,  // async reset, active low
	input  wire logic run,      // count while high, clear when low
	output var  logic expired   // level, high once count reached
);

	logic [31:0] count;
	logic [31:0] next_count;
	logic        next_expired;

	// restart from zero whenever run drops
	always_comb
	begin
		next_count   = count;
		next_expired = expired;
		if (!run)
		begin
			next_count   = 32'h0;
			next_expired = 1'b0;
		end
		else if (count >= 32'(CYCLES - 1))
		begin
			next_expired = 1'b1;
		end
		else
		begin
			next_count = count + 32'h1;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			count   <= 32'h0;
			expired <= 1'b0;
		end
		else
		begin
			count   <= next_count;
			expired <= next_expired;
		end
	end

endmodule

`default_nettype wire

// *** bsg_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "bsg_consts.svh"

// How it works
// - slave and eeprom i2c addresses follow the address-select pin level
// - general pins are sampled as levels only; no edge is ever acted on
// - four two-way general pins and two input-only pins under firmware control
// - boot strap pin stays an undriven input until initialization ends
// - failed boot: strap high mutes converter output, strap low enables it
// - successful boot drives strap pin low, then firmware owns it
// - pins three and four can serve as serial audio inputs a and b
// - high-strap fallback keeps all serial audio outputs inactive
// - high strap: update status, enable slave, then drive strap pin low
// - eeprom read error is recorded in the status word at subaddress 0x02
// - low-strap fallback: status, slave enable, audio passed input to output
// - low-strap fallback also drives strap pin low to show completion
// - with no eeprom the fallback completes about 100 ms after reset
// - once programmed firmware sets each pin input, output or both
// - i2c lines released and status reads answered only after initialization; earlier reads return zero
// - after housekeeping enable i2c master and probe eeprom at 1010 00x
// - no eeprom or read error: master off, slave on, defaults loaded
// - i2c master and slave are never enabled together
module bsg_top #(
	parameter int PROBE_CYCLES = `BSG_PROBE_TIME_MS * `BSG_CLK_KHZ
) (
	input  wire logic        core_clk,               // 250 MHz device clock
	input  wire logic        reset_n,                // async reset, active low
	input  wire logic        addr_select_pin,        // i2c address select pin
	input  wire logic        boot_strap_pin_in,      // strap pin level
	output var  logic        boot_strap_pin_out,     // strap pin drive value
	output var  logic        boot_strap_pin_oe,      // strap pin drive enable
	input  wire logic        general_io_two_in,      // pin two level
	output var  logic        general_io_two_out,     // pin two drive value
	output var  logic        general_io_two_oe,      // pin two drive enable
	input  wire logic        general_io_three_in,    // pin three level
	output var  logic        general_io_three_out,   // pin three drive value
	output var  logic        general_io_three_oe,    // pin three drive enable
	input  wire logic        general_io_four_in,     // pin four level
	output var  logic        general_io_four_out,    // pin four drive value
	output var  logic        general_io_four_oe,     // pin four drive enable
	input  wire logic        general_in_five,        // input-only pin
	input  wire logic        general_in_six,         // input-only pin
	output var  logic        serial_audio_out_a,     // serial audio output a
	output var  logic        serial_audio_out_b,     // serial audio output b
	input  wire logic        housekeep_done,         // memory clear finished
	input  wire logic        eeprom_present,         // probe was answered
	input  wire logic        eeprom_absent,          // probe not answered
	input  wire logic        eeprom_read_err,        // read or header error
	input  wire logic        eeprom_load_done,       // end header read
	input  wire logic        slave_download_done,    // program loaded over slave
	output var  logic        i2c_master_en,          // i2c master enabled
	output var  logic        i2c_slave_en,           // i2c slave enabled
	output var  logic [6:0]  i2c_master_eeprom_addr, // eeprom probe address
	output var  logic [6:0]  i2c_slave_addr,         // own slave address
	output var  logic        i2c_lines_release,      // scl/sda may leave hi-z
	input  wire logic        reg_rd_en,              // status read strobe
	input  wire logic [7:0]  reg_subaddr,            // i2c subaddress
	output var  logic [31:0] reg_rd_data,            // read data, next cycle
	input  wire logic        fw_cfg_load,            // firmware takes the pins
	input  wire logic [3:0]  fw_pin_dir,             // 1 drives pin i
	input  wire logic [3:0]  fw_pin_out,             // drive values
	input  wire logic [1:0]  fw_sdin_sel,            // pins three/four as audio
	input  wire logic        fw_dac_en,              // firmware converter enable
	input  wire logic        dsp_audio_a,            // processed audio a
	input  wire logic        dsp_audio_b,            // processed audio b
	output var  logic [5:0]  gpio_in_level,          // synced pin levels
	output var  logic        serial_audio_in_a,      // audio input a to core
	output var  logic        serial_audio_in_b,      // audio input b to core
	output var  logic        dac_out_en,             // converter output enable
	output var  logic        programmed              // firmware is in charge
);

	bsg_pkg::bsg_state_t state;
	bsg_pkg::bsg_state_t next_state;

	logic [`BSG_SYNC_BITS-1:0] pin_raw;
	logic [`BSG_SYNC_BITS-1:0] pin_sync;
	logic                      probe_timeout;

	logic        read_err;
	logic        no_eeprom;
	logic        load_ok;
	logic        strap_high;
	logic        init_done;
	logic        fw_owned;
	logic [3:0]  pin_oe;
	logic [3:0]  pin_out;
	logic [1:0]  sdin_route;

	logic        next_read_err;
	logic        next_no_eeprom;
	logic        next_load_ok;
	logic        next_strap_high;
	logic        next_init_done;
	logic        next_fw_owned;
	logic        next_master_en;
	logic        next_slave_en;
	logic        next_release;
	logic        next_programmed;
	logic [3:0]  next_pin_oe;
	logic [3:0]  next_pin_out;
	logic [1:0]  next_sdin_route;
	logic        next_audio_out_a;
	logic        next_audio_out_b;
	logic        next_audio_in_a;
	logic        next_audio_in_b;
	logic        next_dac_en;
	logic [31:0] next_rd_data;
	logic [31:0] status_word;

	// pins come from outside the clock domain: every one is synchronised
	assign pin_raw = {addr_select_pin, general_in_six, general_in_five,
		general_io_four_in, general_io_three_in, general_io_two_in,
		boot_strap_pin_in, serial_audio_in_a_unused(), 1'b0};

	bsg_sync #(
		.WIDTH (`BSG_SYNC_BITS)
	) u_sync (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.async_in (pin_raw),
		.sync_out (pin_sync)
	);

	// keeps the spare synchroniser lanes at a defined level
	function automatic logic serial_audio_in_a_unused();
		return 1'b0;
	endfunction

	// probe gives up after the timeout so fallback ends near 100 ms
	bsg_timer #(
		.CYCLES (PROBE_CYCLES)
	) u_probe_timer (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.run      (state == bsg_pkg::ST_PROBE),
		.expired  (probe_timeout)
	);

	// pin i of the four two-way pins, as a level taken from the synchroniser
	function automatic logic io_level(input logic [`BSG_SYNC_BITS-1:0] s, input int i);
		return s[2 + i];
	endfunction

	assign status_word = {27'h0, init_done, strap_high, load_ok, no_eeprom, read_err};

	// boot sequence, pin drive and audio steering
	always_comb
	begin
		next_state       = state;
		next_read_err    = read_err;
		next_no_eeprom   = no_eeprom;
		next_load_ok     = load_ok;
		next_strap_high  = strap_high;
		next_init_done   = init_done;
		next_fw_owned    = fw_owned;
		next_master_en   = i2c_master_en;
		next_slave_en    = i2c_slave_en;
		next_release     = i2c_lines_release;
		next_programmed  = programmed;
		next_pin_oe      = 4'h0;
		next_pin_out     = 4'h0;
		next_sdin_route  = 2'h0;
		next_audio_out_a = 1'b0;
		next_audio_out_b = 1'b0;
		next_dac_en      = 1'b0;
		case (state)
			bsg_pkg::ST_HOUSE:
			begin
				if (housekeep_done)
				begin
					next_master_en = 1'b1;
					next_state     = bsg_pkg::ST_PROBE;
				end
			end
			bsg_pkg::ST_PROBE:
			begin
				if (eeprom_present)
				begin
					next_state = bsg_pkg::ST_LOAD;
				end
				else if (eeprom_absent || probe_timeout)
				begin
					next_no_eeprom = 1'b1;
					next_master_en = 1'b0;
					next_state     = bsg_pkg::ST_FB_SAMPLE;
				end
			end
			bsg_pkg::ST_LOAD:
			begin
				if (eeprom_read_err)
				begin
					next_read_err  = 1'b1;
					next_master_en = 1'b0;
					next_state     = bsg_pkg::ST_FB_SAMPLE;
				end
				else if (eeprom_load_done)
				begin
					next_load_ok   = 1'b1;
					next_master_en = 1'b0;
					next_state     = bsg_pkg::ST_BOOT_DONE;
				end
			end
			bsg_pkg::ST_FB_SAMPLE:
			begin
				// strap still undriven here, so the caught level is external
				next_strap_high = pin_sync[2];
				next_state      = bsg_pkg::ST_FB_STATUS;
			end
			bsg_pkg::ST_FB_STATUS:
			begin
				// master already off a cycle ago, so both never overlap
				next_init_done = 1'b1;
				next_slave_en  = 1'b1;
				next_release   = 1'b1;
				next_state     = bsg_pkg::ST_FB_DRIVE;
			end
			bsg_pkg::ST_FB_DRIVE, bsg_pkg::ST_FALLBACK:
			begin
				next_pin_oe[0]  = 1'b1;
				next_pin_out[0] = 1'b0;
				next_sdin_route = 2'h3;
				if (!strap_high)
				begin
					next_audio_out_a = io_level(pin_sync, 2);
					next_audio_out_b = io_level(pin_sync, 3);
					next_dac_en      = 1'b1;
				end
				// high strap leaves audio outputs and converter off
				if (state == bsg_pkg::ST_FB_DRIVE)
				begin
					next_state = bsg_pkg::ST_FALLBACK;
				end
				else if (slave_download_done)
				begin
					next_programmed = 1'b1;
					next_state      = bsg_pkg::ST_RUN;
				end
			end
			bsg_pkg::ST_BOOT_DONE:
			begin
				next_init_done  = 1'b1;
				next_slave_en   = 1'b1;
				next_release    = 1'b1;
				next_programmed = 1'b1;
				next_state      = bsg_pkg::ST_RUN;
			end
			bsg_pkg::ST_RUN:
			begin
				if (fw_cfg_load)
				begin
					next_fw_owned = 1'b1;
				end
				if (fw_owned)
				begin
					next_pin_oe     = fw_pin_dir;
					next_pin_out    = fw_pin_out;
					next_sdin_route = fw_sdin_sel;
					next_pin_oe[2]  = fw_pin_dir[2] & ~fw_sdin_sel[0];
					next_pin_oe[3]  = fw_pin_dir[3] & ~fw_sdin_sel[1];
				end
				else
				begin
					next_pin_oe[0] = 1'b1;
				end
				next_audio_out_a = dsp_audio_a;
				next_audio_out_b = dsp_audio_b;
				next_dac_en      = fw_dac_en;
			end
			default:
			begin
				next_state = bsg_pkg::ST_HOUSE;
			end
		endcase
		// nothing is driven on any pin before init_done
		if (!init_done && !next_init_done)
		begin
			next_pin_oe = 4'h0;
		end
	end

	// audio inputs taken from pins three and four only when routed there
	assign next_audio_in_a = sdin_route[0] & io_level(pin_sync, 2);
	assign next_audio_in_b = sdin_route[1] & io_level(pin_sync, 3);

	// status reads answer only once the slave is up; others read zero
	always_comb
	begin
		next_rd_data = reg_rd_data;
		if (reg_rd_en)
		begin
			next_rd_data = 32'h0;
			if (i2c_slave_en && reg_subaddr == `BSG_SUB_LOAD_STATUS)
			begin
				next_rd_data = status_word;
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state                  <= bsg_pkg::ST_HOUSE;
			read_err               <= 1'b0;
			no_eeprom              <= 1'b0;
			load_ok                <= 1'b0;
			strap_high             <= 1'b0;
			init_done              <= 1'b0;
			fw_owned               <= 1'b0;
			i2c_master_en          <= 1'b0;
			i2c_slave_en           <= 1'b0;
			i2c_lines_release      <= 1'b0;
			programmed             <= 1'b0;
			pin_oe                 <= 4'h0;
			pin_out                <= 4'h0;
			sdin_route             <= 2'h0;
			serial_audio_out_a     <= 1'b0;
			serial_audio_out_b     <= 1'b0;
			serial_audio_in_a      <= 1'b0;
			serial_audio_in_b      <= 1'b0;
			dac_out_en             <= 1'b0;
			reg_rd_data            <= 32'h0;
			gpio_in_level          <= 6'h0;
			i2c_slave_addr         <= {`BSG_SLAVE_ADDR_BASE, 1'b0};
			i2c_master_eeprom_addr <= {`BSG_EEPROM_ADDR_BASE, 1'b0};
		end
		else
		begin
			state                  <= next_state;
			read_err               <= next_read_err;
			no_eeprom              <= next_no_eeprom;
			load_ok                <= next_load_ok;
			strap_high             <= next_strap_high;
			init_done              <= next_init_done;
			fw_owned               <= next_fw_owned;
			i2c_master_en          <= next_master_en;
			i2c_slave_en           <= next_slave_en;
			i2c_lines_release      <= next_release;
			programmed             <= next_programmed;
			pin_oe                 <= next_pin_oe;
			pin_out                <= next_pin_out;
			sdin_route             <= next_sdin_route;
			serial_audio_out_a     <= next_audio_out_a;
			serial_audio_out_b     <= next_audio_out_b;
			serial_audio_in_a      <= next_audio_in_a;
			serial_audio_in_b      <= next_audio_in_b;
			dac_out_en             <= next_dac_en;
			reg_rd_data            <= next_rd_data;
			gpio_in_level          <= pin_sync[7:2];
			i2c_slave_addr         <= {`BSG_SLAVE_ADDR_BASE, pin_sync[8]};
			i2c_master_eeprom_addr <= {`BSG_EEPROM_ADDR_BASE, pin_sync[8]};
		end
	end

	// pin drive comes straight from the registered enables and values
	assign boot_strap_pin_oe    = pin_oe[0];
	assign boot_strap_pin_out   = pin_out[0];
	assign general_io_two_oe    = pin_oe[1];
	assign general_io_two_out   = pin_out[1];
	assign general_io_three_oe  = pin_oe[2];
	assign general_io_three_out = pin_out[2];
	assign general_io_four_oe   = pin_oe[3];
	assign general_io_four_out  = pin_out[3];

endmodule

`default_nettype wire

// *** bsg_top_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "bsg_consts.svh"

module bsg_top_properties #(
	parameter int PROBE_CYCLES = 16
) (
	input  wire logic        core_clk,               // clock
	input  wire logic        reset_n,                // reset
	input  wire logic        addr_select_pin,        // select pin
	input  wire logic        general_io_three_in,    // audio in a
	input  wire logic        general_io_four_in,     // audio in b
	input  wire logic        housekeep_done,         // pulse
	input  wire logic        eeprom_present,         // pulse
	input  wire logic        eeprom_absent,          // pulse
	input  wire logic        fw_cfg_load,            // pulse
	input  wire logic        boot_strap_pin_out,     // strap value
	input  wire logic        boot_strap_pin_oe,      // strap enable
	input  wire logic        serial_audio_out_a,     // audio out a
	input  wire logic        serial_audio_out_b,     // audio out b
	input  wire logic        i2c_master_en,          // master on
	input  wire logic        i2c_slave_en,           // slave on
	input  wire logic [6:0]  i2c_master_eeprom_addr, // probe address
	input  wire logic [6:0]  i2c_slave_addr,         // own address
	input  wire logic        i2c_lines_release,      // lines free
	input  wire logic        reg_rd_en,              // read strobe
	input  wire logic [7:0]  reg_subaddr,            // subaddress
	input  wire logic [31:0] reg_rd_data,            // read data
	input  wire logic [5:0]  gpio_in_level,          // pin levels
	input  wire logic        dac_out_en,             // converter on
	input  wire logic        programmed              // firmware owns
);
	localparam int PROBE_LIMIT = PROBE_CYCLES + 8;
	logic [31:0] probe_cnt;
	logic        found;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	// probe length; a found memory may load for as long as it likes
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			probe_cnt <= 32'h0;
			found     <= 1'b0;
		end
		else
		begin
			found     <= found | eeprom_present;
			probe_cnt <= probe_cnt + 32'(i2c_master_en && !found);
		end
	end

	sequence seq_fb;
		eeprom_absent ##1 $fell(i2c_master_en);
	endsequence
	sequence seq_slave_up;
		i2c_slave_en && i2c_lines_release;
	endsequence
	sequence seq_strap_low;
		boot_strap_pin_oe && !boot_strap_pin_out;
	endsequence

	never_both_a: assert property (!(i2c_master_en && i2c_slave_en))
		else $error("master and slave enabled together");
	master_cause_a: assert property ($rose(i2c_master_en) |-> $past(housekeep_done))
		else $error("master enabled without housekeeping");
	sel_addr_a: assert property (addr_select_pin [*4] |->
		i2c_slave_addr == {`BSG_SLAVE_ADDR_BASE, 1'b1}
		&& i2c_master_eeprom_addr == {`BSG_EEPROM_ADDR_BASE, 1'b1})
		else $error("addresses ignore select pin");
	fb_order_a: assert property (seq_fb |-> ##2 seq_slave_up ##1 seq_strap_low)
		else $error("fallback steps out of order");
	strap_drive_a: assert property ($rose(boot_strap_pin_oe) && !$past(fw_cfg_load)
		&& !$past(fw_cfg_load, 2) |-> $past(i2c_slave_en) && !boot_strap_pin_out)
		else $error("strap driven early or high");
	dac_strap_a: assert property ($rose(boot_strap_pin_oe) && !programmed
		|-> dac_out_en == !gpio_in_level[0])
		else $error("converter enable disagrees with strap");
	mute_out_a: assert property (!dac_out_en && !programmed
		|-> !serial_audio_out_a && !serial_audio_out_b)
		else $error("audio output active while muted");
	// two synchroniser stages plus the output register: three cycles from pin to output
	pass_audio_a: assert property (dac_out_en && $past(dac_out_en, 3) && !programmed
		|-> serial_audio_out_a == $past(general_io_three_in, 3)
		&& serial_audio_out_b == $past(general_io_four_in, 3))
		else $error("audio not passed through");
	strap_hold_a: assert property ($past(boot_strap_pin_oe) && !programmed
		&& !$past(programmed) |-> $stable(dac_out_en))
		else $error("fallback mode changed");
	status_none_a: assert property (reg_rd_en && (reg_subaddr != 8'h02 || !i2c_slave_en)
		|=> reg_rd_data == 32'h0)
		else $error("refused read returned data");
	probe_time_a: assert property (!(i2c_master_en && probe_cnt > PROBE_LIMIT))
		else $error("probe did not time out");
endmodule

bind bsg_top bsg_top_properties #(.PROBE_CYCLES(PROBE_CYCLES)) u_props (.core_clk, .reset_n,
	.addr_select_pin, .general_io_three_in, .general_io_four_in, .housekeep_done,
	.eeprom_present, .eeprom_absent, .fw_cfg_load, .boot_strap_pin_out, .boot_strap_pin_oe,
	.serial_audio_out_a, .serial_audio_out_b, .i2c_master_en, .i2c_slave_en,
	.i2c_master_eeprom_addr, .i2c_slave_addr, .i2c_lines_release, .reg_rd_en,
	.reg_subaddr, .reg_rd_data, .gpio_in_level, .dac_out_en, .programmed);

`default_nettype wire

// *** bsg_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "bsg_consts.svh"

module bsg_top_tb;
	typedef struct packed {logic strap; logic sel; logic [1:0] mode; logic [31:0] st;} bsg_row_t;
	// mode 0 no answer, 1 read error, 2 probe timeout
	bsg_row_t rows [4] = '{'{1'h1, 1'h0, 2'h0, 32'h1A}, '{1'h0, 1'h1, 2'h0, 32'h12},
		'{1'h0, 1'h0, 2'h1, 32'h11}, '{1'h1, 1'h1, 2'h2, 32'h1A}};
	logic core_clk = 0, reset_n = 0, addr_select_pin = 0, ext_en = 1, ext_level = 1;
	logic general_io_two_in = 0, general_io_three_in = 0, general_io_four_in = 0;
	logic general_in_five = 0, general_in_six = 0, fw_cfg_load = 0, zero = 0;
	logic [5:0] ev = 0;
	logic [3:0] fw_pin_dir = 0, fw_pin_out = 0;
	logic [1:0] fw_sdin_sel = 0;
	logic boot_strap_pin_in, boot_strap_pin_out, boot_strap_pin_oe, general_io_two_out;
	logic general_io_two_oe, general_io_three_out, general_io_three_oe, general_io_four_out;
	logic general_io_four_oe, serial_audio_out_a, serial_audio_out_b, i2c_master_en;
	logic i2c_slave_en, i2c_lines_release, reg_rd_en, serial_audio_in_a, dac_out_en, programmed;
	logic [6:0] i2c_master_eeprom_addr, i2c_slave_addr;
	logic [7:0] reg_subaddr;
	logic [31:0] reg_rd_data;
	logic [5:0] gpio_in_level;
	logic [3:0] mon;
	logic serial_audio_in_b;
	int bad_count = 0, checks = 0;

	assign mon = {programmed, boot_strap_pin_oe, i2c_slave_en, i2c_master_en};

	initial forever #2 core_clk = ~core_clk;

	bsg_top #(.PROBE_CYCLES(50)) dut (.core_clk, .reset_n, .addr_select_pin,
		.boot_strap_pin_in, .boot_strap_pin_out, .boot_strap_pin_oe, .general_io_two_in,
		.general_io_two_out, .general_io_two_oe, .general_io_three_in, .general_io_three_out,
		.general_io_three_oe, .general_io_four_in, .general_io_four_out, .general_io_four_oe,
		.general_in_five, .general_in_six, .serial_audio_out_a, .serial_audio_out_b,
		.housekeep_done(ev[0]), .eeprom_present(ev[1]), .eeprom_absent(ev[2]),
		.eeprom_read_err(ev[3]), .eeprom_load_done(ev[4]), .slave_download_done(ev[5]),
		.i2c_master_en, .i2c_slave_en, .i2c_master_eeprom_addr, .i2c_slave_addr,
		.i2c_lines_release, .reg_rd_en, .reg_subaddr, .reg_rd_data, .fw_cfg_load, .fw_pin_dir,
		.fw_pin_out, .fw_sdin_sel, .fw_dac_en(zero), .dsp_audio_a(zero), .dsp_audio_b(zero),
		.gpio_in_level, .serial_audio_in_a, .serial_audio_in_b, .dac_out_en, .programmed);

	bsg_ctrl_model partner (.core_clk, .reset_n, .ext_en, .ext_level,
		.pin_out(boot_strap_pin_out), .pin_oe(boot_strap_pin_oe), .rd_data(reg_rd_data),
		.pin_wire(boot_strap_pin_in), .rd_en(reg_rd_en), .subaddr(reg_subaddr));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic summarize();
		if (bad_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic pulse(input int k);
		ev[k] = 1'b1;
		tick(1);
		ev[k] = 1'b0;
		tick(1);
	endtask

	// bounded wait on one completion level; running out ends the run
	task automatic wait_hi(input int k);
		int n;
		n = 0;
		while (mon[k] !== 1'b1 && n < 200)
		begin
			tick(1);
			n++;
		end
		if (n == 200)
		begin
			bad_count++;
			summarize();
		end
	endtask

	task automatic boot(input logic strap, input logic sel);
		reset_n = 1'b0;
		ext_en = 1'b1;
		ext_level = strap;
		addr_select_pin = sel;
		tick(6);
		reset_n = 1'b1;
		pulse(0);
		wait_hi(0);
	endtask

	// failed boots: strap level picks mute or pass-through
	task automatic run_row(input bsg_row_t r);
		logic [31:0] d;
		bit ok;
		boot(r.strap, r.sel);
		partner.read_word(8'h02, 0, d, ok);
		check("early_read", d, 32'h0);
		if (r.mode == 2'h0)
			pulse(2);
		if (r.mode == 2'h1)
		begin
			pulse(1);
			pulse(3);
		end
		wait_hi(1);
		check("strap_oe", boot_strap_pin_oe, 1'h0);
		wait_hi(2);
		check("master", i2c_master_en, 1'h0);
		check("dac", dac_out_en, !r.strap);
		check("slave_addr", i2c_slave_addr, {`BSG_SLAVE_ADDR_BASE, r.sel});
		check("probe_addr", i2c_master_eeprom_addr, {`BSG_EEPROM_ADDR_BASE, r.sel});
		for (int i = 0; i < 2; i++)
		begin
			{general_io_four_in, general_io_three_in} = i ? 2'h2 : 2'h1;
			tick(6);
			check("audio", {serial_audio_out_b, serial_audio_out_a}, r.strap ? 2'h0 : i + 1);
		end
		ext_en = 1'b0;
		tick(4);
		check("strap_line", boot_strap_pin_in, 1'h0);
		partner.read_word(8'h02, r.strap, d, ok);
		check("fall_seen", ok, 1'h1);
		check("status", d, r.st);
		partner.read_word(8'h03, 0, d, ok);
		check("unmapped", d, 32'h0);
	endtask

	initial
	begin
		tick(4);
		check("quiet", {mon, i2c_lines_release}, 5'h0);
		check("addr_rst", {i2c_slave_addr, i2c_master_eeprom_addr},
			{`BSG_SLAVE_ADDR_BASE, 1'b0, `BSG_EEPROM_ADDR_BASE, 1'b0});
		for (int i = 0; i < 4; i++)
			run_row(rows[i]);
		// good boot, then firmware takes the pins
		boot(1'b0, 1'b0);
		pulse(1);
		pulse(4);
		wait_hi(3);
		check("master_off", i2c_master_en, 1'h0);
		wait_hi(2);
		tick(1);
		check("strap_low", {boot_strap_pin_oe, boot_strap_pin_out}, 2'h2);
		fw_pin_dir = 4'hF;
		fw_pin_out = 4'hA;
		fw_cfg_load = 1'b1;
		tick(1);
		fw_cfg_load = 1'b0;
		tick(3);
		check("pin_oe", {general_io_four_oe, general_io_three_oe, general_io_two_oe,
			boot_strap_pin_oe}, 4'hF);
		check("pin_out", {general_io_four_out, general_io_three_out, general_io_two_out,
			boot_strap_pin_out}, 4'hA);
		fw_sdin_sel = 2'h3;
		{general_io_four_in, general_io_three_in} = 2'h3;
		tick(5);
		check("sdin", {general_io_four_oe, general_io_three_oe, serial_audio_in_b,
			serial_audio_in_a}, 4'h3);
		fw_pin_dir = 4'h0;
		ext_en = 1'b1;
		// a released strap pin must show the external high again
		ext_level = 1'b1;
		{general_in_six, general_in_five, general_io_four_in, general_io_three_in,
			general_io_two_in} = 5'h15;
		fw_cfg_load = 1'b1;
		tick(1);
		fw_cfg_load = 1'b0;
		tick(5);
		check("levels", gpio_in_level, 6'h2B);
		check("inputs", {general_io_two_oe, boot_strap_pin_oe}, 2'h0);
		summarize();
	end
endmodule

`default_nettype wire
